// >>> bsx_exec.sv
`timescale 1ns/1ps
module bsx_exec
  import bsx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire logic [15:0] next_word,
  input wire logic [PC_W-1:0] instr_addr,
  input wire logic [7:0] rdata,
  input wire bsx_ctx_type ctx,
  output bsx_mem_type mem_q,
  output logic [PC_W-1:0] pc_q,
  output logic pc_load_q,
  output logic flush_q,
  output logic [PC_W-1:0] stack_top_q,
  output logic push_q,
  output bsx_ctx_type shadow_q,
  output logic busy_q
);

  // ************************************************************
  // Phase and state
  // ************************************************************
  // One instruction cycle is four phases; fetch sees busy_q held
  // for each discarded cycle so it may drop the prefetched word.
  typedef enum logic [1:0] {
    ST_EXEC,
    ST_NOP
  } bsx_state_type;

  bsx_state_type st_q, st_d;
  logic [1:0] ph_q, ph_d;
  logic [1:0] nops_q, nops_d;
  logic [15:0] ir_q, ir_d;
  bsx_mem_type mem_d;
  logic [PC_W-1:0] pc_d, stack_top_d;
  logic pc_load_d, flush_d, push_d, busy_d;
  bsx_ctx_type shadow_d;
  logic [7:0] bit_mask;
  logic bit_val, is_skip1, is_skip0, is_inv, is_brr, is_bre, is_call;
  logic take_br, skip_now, two_word_next;
  logic [PC_W-1:0] offs;

  // ************************************************************
  // Decode
  // ************************************************************
  // One compare per bit keeps the mask free of a variable shift.
  for (genvar i = 0; i < 8; i++) begin : g_mask
    assign bit_mask[i] = ir_q[11:9] == 3'(i);
  end

  always_comb begin
    bit_val = |(rdata & bit_mask);
    is_skip1 = ir_q[15:12] == OP_SKIP_ONE;
    is_skip0 = ir_q[15:12] == OP_SKIP_ZERO;
    is_inv = ir_q[15:12] == OP_INVERT;
    is_brr = ir_q[15:8] == OP_BR_RANGE;
    is_bre = ir_q[15:8] == OP_BR_EQUAL;
    is_call = ir_q[15:9] == OP_CALL;
    take_br = (is_brr && ctx.flags[FLAG_RANGE])
      || (is_bre && ctx.flags[FLAG_ZERO]);
    skip_now = (is_skip1 && bit_val) || (is_skip0 && !bit_val);
    two_word_next = (next_word[15:9] == OP_CALL);
    // Sign-extend before doubling so backward branches wrap cleanly.
    offs = {{(PC_W-9){ir_q[7]}}, ir_q[7:0], 1'b0};
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_d = st_q;
    ph_d = ph_q + 2'd1;
    nops_d = nops_q;
    ir_d = ir_q;
    mem_d = '0;
    pc_d = pc_q;
    pc_load_d = 1'b0;
    flush_d = 1'b0;
    stack_top_d = stack_top_q;
    push_d = 1'b0;
    shadow_d = shadow_q;
    // Flags are never written here; the ctx port is input only.
    case (st_q)
      ST_EXEC: begin
        case (ph_q)
          2'd0: begin
            ir_d = instr_valid ? instr : 16'h0000;
          end
          2'd1: begin
            if (is_skip1 || is_skip0 || is_inv) begin
              // Access bit clear forces the access bank.
              mem_d.addr = {ir_q[8] ? ctx.bank : ACCESS_BANK, ir_q[7:0]};
              mem_d.rd = 1'b1;
            end
            if (is_call) begin
              stack_top_d = instr_addr + STEP_CALL;
              push_d = 1'b1;
              if (ir_q[8]) begin
                shadow_d = ctx;
              end
            end
          end
          2'd2: begin
            if (is_inv) begin
              mem_d.addr = {ir_q[8] ? ctx.bank : ACCESS_BANK, ir_q[7:0]};
              mem_d.wdata = rdata ^ bit_mask;
              mem_d.wr = 1'b1;
            end
            if (skip_now) begin
              // Skip drops the prefetch.
              nops_d = two_word_next ? 2'd2 : 2'd1;
              flush_d = 1'b1;
            end
          end
          default: begin
            if (take_br) begin
              pc_d = instr_addr + STEP_ONE + offs;
              pc_load_d = 1'b1;
              flush_d = 1'b1;
              nops_d = 2'd1;
            end else if (is_call) begin
              pc_d = {next_word[11:0], ir_q[7:0], 1'b0};
              pc_load_d = 1'b1;
              flush_d = 1'b1;
              nops_d = 2'd1;
            end
            // Untaken branch and lone second word fall through.
            if (nops_d != 2'd0) begin
              st_d = ST_NOP;
            end
          end
        endcase
      end
      ST_NOP: begin
        if (ph_q == 2'd3) begin
          nops_d = nops_q - 2'd1;
          if (nops_q == 2'd1) begin
            st_d = ST_EXEC;
          end
        end
      end
      default: st_d = ST_EXEC;
    endcase
    // Busy follows the state, so it covers exactly the no-op cycles and
    // falls on the edge at which execution resumes.
    busy_d = st_d == ST_NOP;
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_EXEC;
      ph_q <= 2'd0;
      nops_q <= 2'd0;
      ir_q <= 16'h0000;
      mem_q <= '0;
      pc_q <= '0;
      pc_load_q <= 1'b0;
      flush_q <= 1'b0;
      stack_top_q <= '0;
      push_q <= 1'b0;
      shadow_q <= '0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      nops_q <= nops_d;
      ir_q <= ir_d;
      mem_q <= mem_d;
      pc_q <= pc_d;
      pc_load_q <= pc_load_d;
      flush_q <= flush_d;
      stack_top_q <= stack_top_d;
      push_q <= push_d;
      shadow_q <= shadow_d;
      busy_q <= busy_d;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_test_no_write: assert property (
    (ph_q == 2'd2 && (is_skip1 || is_skip0)) |=> !mem_q.wr)
    else $error("bit test wrote memory");
  a_invert_write: assert property (
    (st_q == ST_EXEC && ph_q == 2'd2 && is_inv) |=>
    mem_q.wr && mem_q.wdata == ($past(rdata) ^ $past(bit_mask)))
    else $error("invert result wrong");
  a_skip_nop: assert property (
    (st_q == ST_EXEC && ph_q == 2'd2 && skip_now) |=> flush_q)
    else $error("skip did not flush");
  a_branch_pc: assert property (
    (st_q == ST_EXEC && ph_q == 2'd3 && take_br) |=> pc_load_q
    && pc_q == $past(instr_addr) + STEP_ONE + $past(offs))
    else $error("branch target wrong");
  a_branch_none: assert property (
    (st_q == ST_EXEC && ph_q == 2'd3 && (is_brr || is_bre) && !take_br)
    |=> !pc_load_q)
    else $error("untaken branch loaded pc");
  a_call_push: assert property (
    (st_q == ST_EXEC && ph_q == 2'd1 && is_call) |=>
    push_q && stack_top_q == $past(instr_addr) + STEP_CALL)
    else $error("call push wrong");
  a_shadow_keep: assert property (
    (st_q == ST_EXEC && ph_q == 2'd1 && is_call && !ir_q[8]) |=>
    $stable(shadow_q))
    else $error("shadow changed");
  a_call_nop: assert property (
    (st_q == ST_EXEC && ph_q == 2'd3 && is_call) |=> busy_q [*4])
    else $error("call nop missing");

  // ************************************************************
  // Elaboration check
  // ************************************************************
  // The call target fills bits 20:1, so a narrower counter cannot hold it.
  if (PC_W != 21) begin : g_pc_width_check
    $error("program counter width must be 21");
  end

  // ************************************************************
  // No-op length helper
  // ************************************************************
  logic [3:0] busy_run_q, busy_run_d;

  always_comb begin
    busy_run_d = busy_q ? 4'(busy_run_q + 4'h1) : 4'h0;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_run_q <= 4'h0;
    end else begin
      busy_run_q <= busy_run_d;
    end
  end

  // ************************************************************
  // Sequences and further checks
  // ************************************************************
  sequence s_nop_cycle;
    busy_q [*4];
  endsequence

  sequence s_two_nops;
    s_nop_cycle ##1 s_nop_cycle;
  endsequence

  a_skip_one: assert property (
    (st_q == ST_EXEC && ph_q == 2'd2 && is_skip1 && bit_val) |=>
    flush_q ##1 busy_q)
    else $error("skip on set bit missing");

  a_skip_zero: assert property (
    (st_q == ST_EXEC && ph_q == 2'd2 && is_skip0 && !bit_val) |=>
    flush_q ##1 busy_q)
    else $error("skip on clear bit missing");

  a_skip_single: assert property (
    (st_q == ST_EXEC && ph_q == 2'd2 && skip_now && !two_word_next) |=>
    ##1 s_nop_cycle ##1 !busy_q)
    else $error("single skip length wrong");

  a_skip_double: assert property (
    (st_q == ST_EXEC && ph_q == 2'd2 && skip_now && two_word_next) |=>
    ##1 s_two_nops ##1 !busy_q)
    else $error("double skip length wrong");

  a_busy_bound: assert property (
    busy_run_q <= 4'h8)
    else $error("no-op run too long");

  a_bank_read: assert property (
    mem_q.rd |->
    mem_q.addr[11:8] == (ir_q[8] ? ctx.bank : ACCESS_BANK))
    else $error("read bank wrong");

  a_bank_write: assert property (
    mem_q.wr |->
    mem_q.addr[11:8] == (ir_q[8] ? ctx.bank : ACCESS_BANK))
    else $error("write bank wrong");

  a_range_taken: assert property (
    (st_q == ST_EXEC && ph_q == 2'd3 && is_brr && ctx.flags[FLAG_RANGE])
    |=> pc_load_q && flush_q)
    else $error("overflow branch not taken");

  a_equal_taken: assert property (
    (st_q == ST_EXEC && ph_q == 2'd3 && is_bre && ctx.flags[FLAG_ZERO])
    |=> pc_load_q && flush_q)
    else $error("zero branch not taken");

  a_branch_fall: assert property (
    (st_q == ST_EXEC && ph_q == 2'd3 && (is_brr || is_bre) && !take_br)
    |=> $stable(pc_q) && !flush_q)
    else $error("untaken branch moved pc");

  a_call_target: assert property (
    (st_q == ST_EXEC && ph_q == 2'd3 && is_call) |=> pc_load_q
    && pc_q == {$past(next_word[11:0]), $past(ir_q[7:0]), 1'b0})
    else $error("call target wrong");

  a_call_shadow: assert property (
    (st_q == ST_EXEC && ph_q == 2'd1 && is_call && ir_q[8]) |=>
    shadow_q == $past(ctx))
    else $error("shadow copy wrong");

  a_second_idle: assert property (
    (st_q == ST_EXEC && ir_q[15:12] == OP_SECOND) |=>
    !pc_load_q && !flush_q && !push_q && !mem_q.wr)
    else $error("lone second word acted");

  a_flush_single: assert property (
    flush_q |=> !flush_q)
    else $error("flush held too long");

  a_push_single: assert property (
    push_q |=> !push_q)
    else $error("push held too long");

  a_nop_quiet: assert property (
    (st_q == ST_NOP) |=> !mem_q.wr && !push_q && !pc_load_q)
    else $error("no-op cycle acted");

  a_test_no_load: assert property (
    (st_q == ST_EXEC && ph_q == 2'd3 && (is_skip1 || is_skip0)) |=>
    !pc_load_q && !mem_q.wr)
    else $error("bit test loaded pc");

endmodule

// >>> bsx_pkg.sv
// Summary of operation
// - 1010 bbba pattern skips when bit set.
// - Taken skip discards prefetch, adds no-op cycle.
// - Skipping a two-word instruction costs three cycles.
// - Access bit zero selects access bank.
// - Bit test reads f, never writes.
// - 0111 bbba pattern inverts bit, writes back.
// - 1110 0100 branches on overflow flag.
// - 1110 0000 branches on zero flag.
// - Taken branch two cycles, untaken one.
// - Untaken branch continues at address plus two.
// - Call pushes address plus four onto stack.
// - Shadow bit one copies accumulator, status, bank.
// - Call target loads program counter bits 20:1.
// - Call is two words, second starts 1111.
// - Call takes two cycles, second is no-op.
// - These instructions leave status flags unchanged.
// - 1011 bbba pattern skips when bit clear.
package bsx_pkg;

  localparam int PC_W = 21;
  localparam logic [3:0] OP_SKIP_ONE = 4'ha;
  localparam logic [3:0] OP_SKIP_ZERO = 4'hb;
  localparam logic [3:0] OP_INVERT = 4'h7;
  localparam logic [7:0] OP_BR_RANGE = 8'he4;
  localparam logic [7:0] OP_BR_EQUAL = 8'he0;
  localparam logic [6:0] OP_CALL = 7'h76;
  localparam logic [3:0] OP_SECOND = 4'hf;
  localparam logic [PC_W-1:0] STEP_ONE = 21'h00_0002;
  localparam logic [PC_W-1:0] STEP_CALL = 21'h00_0004;
  localparam logic [3:0] ACCESS_BANK = 4'h0;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_RANGE = 3;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } bsx_mem_type;

  typedef struct packed {
    logic [7:0] accumulator;
    logic [7:0] flags;
    logic [3:0] bank;
  } bsx_ctx_type;

endpackage

// >>> bsx_mem_model.sv
`timescale 1ns/1ps
// ****
// Data memory partner.
// ****
module bsx_mem_model
  import bsx_pkg::*;
(
  input wire logic ref_clk,
  input wire bsx_mem_type mem_q,
  output logic [7:0] rdata
);
  logic [7:0] mem [4096];
  logic [7:0] last_q;
  // Contents mix in the bank, so a wrong bank reads a different byte.
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i) ^ {4'(i >> 8), 4'h0};
    end
    last_q = 8'h00;
  end
  // An idle port shows the inverse of its last byte, never a held value.
  assign rdata = mem_q.rd ? mem[mem_q.addr] : ~last_q;
  always @(posedge ref_clk) begin
    if (mem_q.rd) last_q <= mem[mem_q.addr];
    if (mem_q.wr) mem[mem_q.addr] <= mem_q.wdata;
  end
endmodule

// >>> bit_skip_branch_call_exec_tb.sv
`timescale 1ns/1ps
// ****
// Table rows first, then reset in mid-run.
// ****
module bit_skip_branch_call_exec_tb;
  import bsx_pkg::*;
  typedef struct packed {
    logic [15:0] instr, nw;
    logic [20:0] addr, pc;
    logic [7:0] flags;
    logic [1:0] nops;
    logic wr, pcl;
  } bsx_row_type;
  logic ref_clk = 1'b0, rst = 1'b1, instr_valid = 1'b0;
  logic [15:0] instr = 16'h0, next_word = 16'h0;
  logic [PC_W-1:0] instr_addr = '0, pc_q, stack_top_q;
  logic [7:0] rdata;
  logic pc_load_q, flush_q, push_q, busy_q;
  bsx_ctx_type ctx = '0, shadow_q, exp_sh = '0;
  bsx_mem_type mem_q;
  int errors = 0, n_checks = 0;
  bsx_row_type rows [12] = '{
    {16'had10, 16'h0, 21'h100, 21'h0, 8'h00, 2'd1, 1'b0, 1'b0},
    {16'ha110, 16'h0, 21'h100, 21'h0, 8'h00, 2'd0, 1'b0, 1'b0},
    {16'hb110, 16'hec00, 21'h100, 21'h0, 8'h00, 2'd2, 1'b0, 1'b0},
    {16'hb810, 16'h0, 21'h100, 21'h0, 8'h00, 2'd0, 1'b0, 1'b0},
    {16'h7710, 16'h0, 21'h100, 21'h0, 8'h0c, 2'd0, 1'b1, 1'b0},
    {16'he480, 16'h0, 21'h0, 21'h1f_ff02, 8'h08, 2'd1, 1'b0, 1'b1},
    {16'he47f, 16'h0, 21'h0, 21'h0, 8'h04, 2'd0, 1'b0, 1'b0},
    {16'he07f, 16'h0, 21'h100, 21'h200, 8'h04, 2'd1, 1'b0, 1'b1},
    {16'he0ff, 16'h0, 21'h0, 21'h0, 8'h08, 2'd0, 1'b0, 1'b0},
    {16'hed34, 16'hf123, 21'h100, 21'h2_4668, 8'h00, 2'd1, 1'b0, 1'b1},
    {16'hec56, 16'hf789, 21'h1f_fffc, 21'hf_12ac, 8'h0c, 2'd1, 1'b0, 1'b1},
    {16'hf123, 16'h0, 21'h0, 21'h0, 8'h0c, 2'd0, 1'b0, 1'b0}
  };
  bsx_exec u_bsx_exec (.ref_clk, .rst, .instr, .instr_valid, .next_word,
    .instr_addr, .rdata, .ctx, .mem_q, .pc_q, .pc_load_q, .flush_q,
    .stack_top_q, .push_q, .shadow_q, .busy_q);
  bsx_mem_model u_bsx_mem_model (.ref_clk, .mem_q, .rdata);
  always #20 ref_clk = ~ref_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic do_reset();
    rst = 1'b1;
    instr_valid = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    check(mem_q, 0);
    check({pc_load_q, flush_q, push_q, busy_q, pc_q}, 0);
    check(shadow_q, 0);
    rst = 1'b0;
    exp_sh = '0;
  endtask
  // Inputs move 1 ns after the edge, so sampling never races driving.
  task automatic run_row(input bsx_row_type r, input int cut);
    int rd_at = 15, wr_at = 15, pl_at = 15, pu_n = 0, fl_n = 0, bz_n = 0;
    logic [11:0] ma;
    logic [7:0] wd;
    logic bitop, call;
    bitop = r.instr[15:12] inside {4'ha, 4'hb, 4'h7};
    call = r.instr[15:9] == 7'h76;
    ma = {r.instr[8] ? 4'h5 : ACCESS_BANK, r.instr[7:0]};
    wd = ma[7:0] ^ {ma[11:8], 4'h0} ^ (8'h01 << r.instr[11:9]);
    instr = r.instr;
    next_word = r.nw;
    instr_addr = r.addr;
    ctx = {r.instr[7:0], r.flags, 4'h5};
    instr_valid = 1'b1;
    for (int k = 0; k < cut; k++) begin
      @(posedge ref_clk);
      #1;
      // Valid drops after the test cycle, so no-op cycles see no new word.
      if (k == 3) instr_valid = 1'b0;
      if (mem_q.rd === 1'b1) rd_at = k;
      if (mem_q.rd === 1'b1) check(mem_q.addr, ma);
      if (mem_q.wr === 1'b1) wr_at = k;
      if (mem_q.wr === 1'b1) check(mem_q.wdata, wd);
      if (pc_load_q === 1'b1) pl_at = k;
      if (pc_load_q === 1'b1) check(pc_q, r.pc);
      if (push_q === 1'b1) check(stack_top_q, 21'(r.addr + STEP_CALL));
      pu_n += (push_q === 1'b1);
      fl_n += (flush_q === 1'b1);
      bz_n += (busy_q === 1'b1);
    end
    if (cut < 12) return;
    check(rd_at, bitop ? 1 : 15);
    check(wr_at, r.wr ? 2 : 15);
    check(pl_at, r.pcl ? 3 : 15);
    check(pu_n, call);
    check(fl_n, r.nops != 0);
    check(bz_n, 4 * r.nops);
    if (call && r.instr[8]) exp_sh = ctx;
    check(shadow_q, exp_sh);
  endtask
  initial begin
    do_reset();
    foreach (rows[i]) begin
      run_row(rows[i], 12);
      $display("row %0d done", i);
    end
    run_row(rows[9], 6);
    do_reset();
    run_row(rows[0], 12);
    $display("reset in mid-call done");
    stop_test();
  end
  // About twelve cycles a row; the span allows ten times the whole run.
  initial begin
    #(40 * 2000);
    errors++;
    stop_test();
  end
endmodule
